// ==== inc/adcr_cfg.svh ====
// Contract
// RULE1: Two-bit power mode field, 00 is normal
// RULE2: Mode 10 stops datapath clocks, link stays on
// RULE3: Mode 11 stops clocks, resets datapath, link off
// RULE4: Core select bits gate next command, reset 1
// RULE5: Pair A/B gets command only when bit0 set
// RULE6: Pair select bit1 gates pair C/D likewise
// RULE7: Eight-bit scratch register, resets to 0x07
`ifndef ADCR_CFG_SVH
`define ADCR_CFG_SVH

// Register byte offsets
`define ADCR_OFS_POWER    16'h0002
`define ADCR_OFS_CATEGORY 16'h0003
`define ADCR_OFS_IDLOW    16'h0004
`define ADCR_OFS_RATE     16'h0006
`define ADCR_OFS_CORESEL  16'h0008
`define ADCR_OFS_PAIRSEL  16'h0009
`define ADCR_OFS_SCRATCH  16'h000a
`define ADCR_OFS_IFREV    16'h000b
`define ADCR_OFS_MAKERLO  16'h000c
`define ADCR_OFS_MAKERHI  16'h000d

// Field positions
`define ADCR_POWER_MSB    1
`define ADCR_POWER_LSB    0
`define ADCR_SEL_BIT_LO   0
`define ADCR_SEL_BIT_HI   1
`define ADCR_RATE_MSB     7
`define ADCR_RATE_LSB     4

// Reset values
`define ADCR_RST_POWER    2'h0
`define ADCR_RST_CORESEL  2'h3
`define ADCR_RST_PAIRSEL  2'h3
`define ADCR_RST_SCRATCH  8'h07
`define ADCR_RST_RDDATA   8'h00

`endif

// ==== inc/adcr_pkg.sv ====
package adcr_pkg;

   // Power mode codes as stored in the control field
   typedef enum logic [1:0] {
      PM_NORMAL   = 2'h0,
      PM_UNUSED   = 2'h1,
      PM_STANDBY  = 2'h2,
      PM_POWERDN  = 2'h3
   } adcr_pmode_t;

   // One register access from the serial engine
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } adcr_req_t;

   // Power controls toward the converter
   typedef struct packed {
      logic dpClkEn;
      logic dpReset;
      logic linkEn;
      logic outEn;
   } adcr_pwr_t;

endpackage

// ==== src/adcr_chip_config_regs.sv ====
`timescale 1ns/100ps
`include "adcr_cfg.svh"

module adcr_chip_config_regs #(
   parameter logic [7:0] CATEGORY   = 8'h11, // Arbitrary value
   parameter logic [7:0] ID_LOW     = 8'h22, // Arbitrary value
   parameter logic [3:0] RATE_CLASS = 4'h9,  // Arbitrary value
   parameter logic [7:0] IF_REV     = 8'h33, // Arbitrary value
   parameter logic [7:0] MAKER_LO   = 8'h44, // Arbitrary value
   parameter logic [7:0] MAKER_HI   = 8'h55  // Arbitrary value
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              reset_n,
   // Register access from the serial engine
   input  wire adcr_pkg::adcr_req_t req,
   output logic [7:0]             rdData_r,
   output logic                   rdValid_r,
   // Power controls
   output adcr_pkg::adcr_pwr_t    pwr_r,
   output logic [1:0]             powerMode_r,
   // Command routing toward cores A, B, C, D (bit 0 is A)
   output logic [1:0]             coreSel_r,
   output logic [1:0]             pairSel_r,
   output logic [3:0]             coreRoute_r
);

   // Stored register state
   logic [7:0] scratch_r;

   // Address decode
   wire hitPower   = (req.addr == `ADCR_OFS_POWER);
   wire hitCat     = (req.addr == `ADCR_OFS_CATEGORY);
   wire hitIdLow   = (req.addr == `ADCR_OFS_IDLOW);
   wire hitRate    = (req.addr == `ADCR_OFS_RATE);
   wire hitCoreSel = (req.addr == `ADCR_OFS_CORESEL);
   wire hitPairSel = (req.addr == `ADCR_OFS_PAIRSEL);
   wire hitScratch = (req.addr == `ADCR_OFS_SCRATCH);
   wire hitIfRev   = (req.addr == `ADCR_OFS_IFREV);
   wire hitMakerLo = (req.addr == `ADCR_OFS_MAKERLO);
   wire hitMakerHi = (req.addr == `ADCR_OFS_MAKERHI);

   // Write strobes; read-only and unmapped writes are dropped
   wire wrPower   = req.wr & hitPower;
   wire wrCoreSel = req.wr & hitCoreSel;
   wire wrPairSel = req.wr & hitPairSel;
   wire wrScratch = req.wr & hitScratch;

   // Next values of writable fields
   wire [1:0] powerMode_nxt = wrPower ?
      req.wdata[`ADCR_POWER_MSB:`ADCR_POWER_LSB] : powerMode_r; // RULE1
   wire [1:0] coreSel_nxt = wrCoreSel ?
      req.wdata[`ADCR_SEL_BIT_HI:`ADCR_SEL_BIT_LO] : coreSel_r; // RULE4
   wire [1:0] pairSel_nxt = wrPairSel ?
      req.wdata[`ADCR_SEL_BIT_HI:`ADCR_SEL_BIT_LO] : pairSel_r; // RULE5
   wire [7:0] scratch_nxt = wrScratch ? req.wdata : scratch_r; // RULE7

   // Read mux; reserved bits and unmapped offsets read as zero
   logic [7:0] rdMux;
   always_comb begin
      rdMux = 8'h00;
      if (hitPower)
         rdMux = {6'h00, powerMode_r};
      else if (hitCat)
         rdMux = CATEGORY;
      else if (hitIdLow)
         rdMux = ID_LOW;
      else if (hitRate)
         rdMux = {RATE_CLASS, 4'h0};
      else if (hitCoreSel)
         rdMux = {6'h00, coreSel_r};
      else if (hitPairSel)
         rdMux = {6'h00, pairSel_r};
      else if (hitScratch)
         rdMux = scratch_r; // RULE7
      else if (hitIfRev)
         rdMux = IF_REV;
      else if (hitMakerLo)
         rdMux = MAKER_LO;
      else if (hitMakerHi)
         rdMux = MAKER_HI;
   end

   // Power mode decode; the unused code keeps full power so a
   // stray write never silently shuts the link down
   adcr_pkg::adcr_pwr_t pwr_nxt;
   always_comb begin
      case (adcr_pkg::adcr_pmode_t'(powerMode_nxt))
         adcr_pkg::PM_NORMAL: begin
            pwr_nxt = '{dpClkEn: 1'b1, dpReset: 1'b0,
                        linkEn: 1'b1, outEn: 1'b1}; // RULE1
         end
         adcr_pkg::PM_STANDBY: begin
            pwr_nxt = '{dpClkEn: 1'b0, dpReset: 1'b0,
                        linkEn: 1'b1, outEn: 1'b1}; // RULE2
         end
         adcr_pkg::PM_POWERDN: begin
            pwr_nxt = '{dpClkEn: 1'b0, dpReset: 1'b1,
                        linkEn: 1'b0, outEn: 1'b0}; // RULE3
         end
         default: begin
            pwr_nxt = '{dpClkEn: 1'b1, dpReset: 1'b0,
                        linkEn: 1'b1, outEn: 1'b1};
         end
      endcase
   end

   // Core route: a core takes the command only if both its
   // channel bit and its pair bit are set
   wire [3:0] coreRoute_nxt = {
      pairSel_nxt[1] & coreSel_nxt[1],  // D
      pairSel_nxt[1] & coreSel_nxt[0],  // C, RULE6
      pairSel_nxt[0] & coreSel_nxt[1],  // B
      pairSel_nxt[0] & coreSel_nxt[0]   // A, RULE5 RULE4
   };

   // Control registers
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         powerMode_r <= `ADCR_RST_POWER;
         coreSel_r   <= `ADCR_RST_CORESEL;
         pairSel_r   <= `ADCR_RST_PAIRSEL;
         scratch_r   <= `ADCR_RST_SCRATCH;
      end else begin
         powerMode_r <= powerMode_nxt;
         coreSel_r   <= coreSel_nxt;
         pairSel_r   <= pairSel_nxt; // RULE6
         scratch_r   <= scratch_nxt;
      end
   end

   // Derived outputs, registered so they follow the field at once
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pwr_r       <= '{dpClkEn: 1'b1, dpReset: 1'b0,
                          linkEn: 1'b1, outEn: 1'b1};
         coreRoute_r <= 4'hf;
      end else begin
         pwr_r       <= pwr_nxt; // RULE2 RULE3
         coreRoute_r <= coreRoute_nxt; // RULE4
      end
   end

   // Read answer one cycle after the request
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdData_r  <= `ADCR_RST_RDDATA;
         rdValid_r <= 1'b0;
      end else begin
         rdValid_r <= req.rd;
         if (req.rd)
            rdData_r <= rdMux;
      end
   end

endmodule

// ==== tb/adcr_chk.sv ====
`timescale 1ns/100ps
// Sees only the register bank ports
module adcr_chk (
   input wire logic                clk,
   input wire logic                reset_n,
   input wire adcr_pkg::adcr_req_t req,
   input wire logic [7:0]          rdData_r,
   input wire logic                rdValid_r,
   input wire adcr_pkg::adcr_pwr_t pwr_r,
   input wire logic [1:0]          powerMode_r,
   input wire logic [1:0]          coreSel_r,
   input wire logic [1:0]          pairSel_r,
   input wire logic [3:0]          coreRoute_r
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Stored modes 00, 10 and 11 always match their controls
   a_mode_normal: assert property (powerMode_r == 2'h0 |-> pwr_r == 4'hb)
      else $error("normal controls");
   a_mode_standby: assert property (powerMode_r == 2'h2 |-> pwr_r == 4'h3)
      else $error("standby controls");
   a_mode_off: assert property (powerMode_r == 2'h3 |-> pwr_r == 4'h4)
      else $error("powerdown controls");
   // Core select writes land one cycle later; pair select gates the routes
   a_core_write: assert property (req.wr && req.addr == 16'h8
      |=> coreSel_r == $past(req.wdata[1:0])) else $error("core select");
   a_pair_ab: assert property (!pairSel_r[0] |-> coreRoute_r[1:0] == 2'h0)
      else $error("pair ab route");
   a_pair_cd: assert property (coreRoute_r[3:2] == ({2{pairSel_r[1]}}
      & coreSel_r)) else $error("pair cd route");
   // Host leaves one idle cycle between accesses
   a_scratch_back: assert property (req.wr && req.addr == 16'ha ##2
      req.rd && req.addr == 16'ha |=> rdData_r == $past(req.wdata, 3))
      else $error("scratch readback");
endmodule

// ==== tb/adcr_host.sv ====
`timescale 1ns/100ps
// Serial engine side; idle bus shows inverted leftovers
module adcr_host (
   input wire logic          clk,
   input wire logic [7:0]    rdData_r,
   input wire logic          rdValid_r,
   output adcr_pkg::adcr_req_t req
);
   initial req = '0;
   // One access, answer sampled after the taking edge
   task automatic xfer(input logic w, input logic [15:0] a,
                       input logic [7:0] d, output logic [8:0] q);
      @(posedge clk);
      req <= '{w, !w, a, d};
      @(posedge clk);
      req <= '{1'b0, 1'b0, ~a, ~d};
      #1 q = {rdValid_r, rdData_r};
   endtask
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
   logic                clk = 1'b0;
   logic                reset_n = 1'b0;
   logic [31:0]         seed = 32'hb3ac;
   int                  n_errors = 0;
   int                  tests_run = 0;
   int                  mem [16] = '{0, 0, 0, 17, 34, 0, 144, 0, 3, 3, 7,
                                     51, 68, 85, 0, 0};
   int                  msk [16] = '{0, 0, 3, 0, 0, 0, 0, 0, 3, 3, 255,
                                     0, 0, 0, 0, 0};
   logic [3:0]          pw [4] = '{4'hb, 4'hb, 4'h3, 4'h4};
   logic [8:0]          q;
   logic [31:0]         r;
   logic [15:0]         a;
   logic [7:0]          d;
   adcr_pkg::adcr_req_t req;
   adcr_pkg::adcr_pwr_t pwr_r;
   logic [7:0]          rdData_r;
   logic [1:0]          powerMode_r, coreSel_r, pairSel_r;
   logic [3:0]          coreRoute_r;
   logic                rdValid_r;

   always #2.5 clk = ~clk;
   adcr_host host (.clk(clk), .rdData_r(rdData_r), .rdValid_r(rdValid_r),
                   .req(req));
   adcr_chip_config_regs dut (.clk(clk), .reset_n(reset_n), .req(req),
      .rdData_r(rdData_r), .rdValid_r(rdValid_r), .pwr_r(pwr_r),
      .powerMode_r(powerMode_r), .coreSel_r(coreSel_r),
      .pairSel_r(pairSel_r), .coreRoute_r(coreRoute_r));

   // Xorshift stream, fixed start
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // Compare task, counts every check
   task automatic chk(input string nm, input logic [8:0] e,
                      input logic [8:0] g);
      tests_run++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s exp %h got %h", nm, e, g);
      end
   endtask

   task automatic report_and_stop();
      $display("Errors %0d of %0d checks", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Hang guard, far beyond the expected few hundred cycles
   initial begin
      repeat (4000) @(posedge clk);
      n_errors++;
      report_and_stop();
   end

   // Reset values, then random writes with readback
   initial begin
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      for (int i = 0; i < 16; i++) begin
         host.xfer(1'b0, 16'(i), 8'h00, q);
         chk("reset read", {1'b1, 8'(mem[i])}, q);
      end
      for (int i = 0; i < 64; i++) begin
         r = xs();
         a = (i < 4) ? 16'h2 : {12'h0, r[3:0]};
         d = (i < 4) ? 8'(i) : r[15:8];
         host.xfer(1'b1, a, d, q);
         mem[a] = (mem[a] & ~msk[a]) | (d & msk[a]);
         host.xfer(1'b0, a, 8'h00, q);
         chk("readback", {1'b1, 8'(mem[a])}, q);
         chk("power", 9'(pw[mem[2] & 3]), 9'(pwr_r));
         chk("route", {5'h0, mem[9][1] & mem[8][1], mem[9][1] & mem[8][0],
             mem[9][0] & mem[8][1], mem[9][0] & mem[8][0]},
             9'(coreRoute_r));
      end
      report_and_stop();
   end
endmodule

bind adcr_chip_config_regs adcr_chk u_chk (.clk(clk), .reset_n(reset_n),
   .req(req), .rdData_r(rdData_r), .rdValid_r(rdValid_r), .pwr_r(pwr_r),
   .powerMode_r(powerMode_r), .coreSel_r(coreSel_r),
   .pairSel_r(pairSel_r), .coreRoute_r(coreRoute_r));
